/* trw_pkg.sv */
// Purpose: Constants and types of the table read/write unit
// Assumes: Core issues one table or latch command at a time
// Notes:   Byte-wide register port, one interrupt output
`default_nettype none
package trw_pkg;
	// Register map, byte offsets
	localparam logic [3:0] REG_PTR_LO = 4'h0;
	localparam logic [3:0] REG_PTR_HI = 4'h1;
	localparam logic [3:0] REG_LAT_LO = 4'h2;
	localparam logic [3:0] REG_LAT_HI = 4'h3;
	localparam logic [3:0] REG_MODE   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_MASK   = 4'h6;
	localparam logic [3:0] REG_STATE  = 4'h7;
	// Mode fields
	localparam int MODE_EXT_EN  = 0;
	localparam int MODE_ALL_EXT = 1;
	localparam logic [1:0] MODE_RESET = 2'h0;
	// Status events
	localparam int EV_LW_END = 0;
	localparam int EV_ABORT  = 1;
	localparam int EV_XW_END = 2;
	localparam int EV_RD_END = 3;
	localparam int EV_NUM    = 4;
	// Interrupt source slots, lowest index wins
	localparam int SRC_PIN  = 0;
	localparam int SRC_TMR  = 1;
	localparam int SRC_TCK  = 2;
	localparam int SRC_PERI = 3;
	localparam logic [15:0] INT_WORDS_DEF = 16'h1000;
	typedef enum logic [1:0] {
		OP_LATCH_BYTE_WRITE = 2'h0,
		OP_TABLE_WRITE      = 2'h1,
		OP_LATCH_BYTE_READ  = 2'h2,
		OP_TABLE_READ       = 2'h3
	} trw_op_type;
	typedef struct packed {
		trw_op_type  op;
		logic        hi;
		logic        inc;
		logic [7:0]  data;
	} trw_cmd_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_XW1  = 3'h1,
		ST_XW2  = 3'h3,
		ST_LW   = 3'h2,
		ST_RD   = 3'h4
	} trw_state_type;
endpackage
`default_nettype wire

/* trw_unit.sv */
// Purpose: Table read/write unit between data space and program memory
// Assumes: Memory read data valid in the cycle mem_re is high
// Notes:   Register port has no wait states
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module trw_unit #(
	parameter logic [15:0] INT_WORDS = trw_pkg::INT_WORDS_DEF
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	// Register port
	input  wire logic [3:0]           addr,
	input  wire logic [7:0]           wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output var  logic [7:0]           rdata,
	// Core command port
	input  wire logic                 cmd_valid,
	input  wire trw_pkg::trw_cmd_type cmd,
	output var  logic                 stall,
	output var  logic                 res_valid,
	output var  logic [7:0]           res_data,
	// Interrupt sources
	input  wire logic [3:0]           src_en,
	input  wire logic [3:0]           src_flag,
	input  wire logic                 global_vector_disable,
	output var  logic [2:0]           flag_clr,
	output var  logic                 periph_ack,
	output var  logic                 vector_req,
	// Program memory
	output var  logic [15:0]          mem_addr,
	output var  logic [15:0]          mem_wdata,
	input  wire logic [15:0]          mem_rdata,
	output var  logic                 mem_re,
	output var  logic                 mem_we,
	output var  logic                 prog_en,
	output var  logic                 mem_ext,
	// Interrupt output
	output var  logic                 irq
);
	trw_pkg::trw_state_type  state;
	logic [15:0]             program_word_pointer;
	logic [15:0]             program_word_latch;
	logic [15:0]             next_latch;
	logic [15:0]             rd_addr;
	logic [1:0]              mode;
	logic [3:0]              status;
	logic [3:0]              mask;
	logic [3:0]              events;
	logic [2:0]              fast;
	logic [2:0]              fast_top;
	logic                    term;
	logic                    peri;
	logic                    issue;
	logic                    is_tw;
	logic                    is_tr;
	logic                    tw_ext;
	logic                    rd_ext;
	logic                    abort;
	logic                    lw_end;
	logic                    xw_end;
	logic                    inc_now;

	// Pending sources and the winning fast one
	assign fast     = src_en[2:0] & src_flag[2:0];
	assign peri     = src_en[trw_pkg::SRC_PERI] & src_flag[trw_pkg::SRC_PERI];
	assign term     = (|fast) | peri;
	assign fast_top = {fast[2] & ~fast[1] & ~fast[0], fast[1] & ~fast[0], fast[0]};

	// Command decode
	assign issue  = cmd_valid & ~stall;
	assign is_tw  = issue & (cmd.op == trw_pkg::OP_TABLE_WRITE);
	assign is_tr  = issue & (cmd.op == trw_pkg::OP_TABLE_READ);
	assign rd_addr = cmd.inc ? program_word_pointer + 16'h0001 : program_word_pointer;
	// External only in extended or processor modes
	assign tw_ext = mode[trw_pkg::MODE_ALL_EXT] |
		(mode[trw_pkg::MODE_EXT_EN] & (program_word_pointer >= INT_WORDS));
	assign rd_ext = mode[trw_pkg::MODE_ALL_EXT] |
		(mode[trw_pkg::MODE_EXT_EN] & (rd_addr >= INT_WORDS));
	assign abort  = is_tw & ~tw_ext & term;
	assign lw_end = (state == trw_pkg::ST_LW) & term;
	assign xw_end = (state == trw_pkg::ST_XW2);
	assign inc_now = (is_tr | (is_tw & ~abort)) & cmd.inc;

	// Byte merged into the latch ahead of a write
	always_comb begin
		next_latch = program_word_latch;
		if (cmd.hi) begin
			next_latch[15:8] = cmd.data;
		end else begin
			next_latch[7:0] = cmd.data;
		end
	end

	// Word pointer; a software write beats the increment
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			program_word_pointer <= 16'h0000;
		end else if (wr && addr == trw_pkg::REG_PTR_LO) begin
			program_word_pointer[7:0] <= wdata;
		end else if (wr && addr == trw_pkg::REG_PTR_HI) begin
			program_word_pointer[15:8] <= wdata;
		end else if (inc_now) begin
			program_word_pointer <= program_word_pointer + 16'h0001;
		end
	end

	// Word latch: byte loads, or reload after a table read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			program_word_latch <= 16'h0000;
		end else if (issue && (cmd.op == trw_pkg::OP_LATCH_BYTE_WRITE || is_tw)) begin
			program_word_latch <= next_latch;
		end else if (state == trw_pkg::ST_RD) begin
			program_word_latch <= mem_rdata;
		end
	end

	// Sequencer and memory strobes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= trw_pkg::ST_IDLE;
			stall     <= 1'b0;
			mem_addr  <= 16'h0000;
			mem_wdata <= 16'h0000;
			mem_re    <= 1'b0;
			mem_we    <= 1'b0;
			prog_en   <= 1'b0;
			mem_ext   <= 1'b0;
		end else begin
			mem_re <= 1'b0;
			mem_we <= 1'b0;
			case (state)
				trw_pkg::ST_IDLE: begin
					if (is_tw && !abort) begin
						mem_addr  <= program_word_pointer;
						mem_wdata <= next_latch;
						mem_ext   <= tw_ext;
						stall     <= 1'b1;
						if (tw_ext) begin
							state <= trw_pkg::ST_XW1;
						end else begin
							// Programming stays on until a source ends it
							prog_en <= 1'b1;
							state   <= trw_pkg::ST_LW;
						end
					end else if (is_tr) begin
						// Reload address is the pointer, stepped first when inc is set
						mem_addr <= rd_addr;
						mem_ext  <= rd_ext;
						mem_re   <= 1'b1;
						stall    <= 1'b1;
						state    <= trw_pkg::ST_RD;
					end
				end
				trw_pkg::ST_LW: begin
					if (term) begin
						prog_en <= 1'b0;
						stall   <= 1'b0;
						state   <= trw_pkg::ST_IDLE;
					end
				end
				trw_pkg::ST_XW1: begin
					// Interrupts are ignored until the second cycle ends
					mem_we <= 1'b1;
					state  <= trw_pkg::ST_XW2;
				end
				trw_pkg::ST_XW2: begin
					stall <= 1'b0;
					state <= trw_pkg::ST_IDLE;
				end
				trw_pkg::ST_RD: begin
					stall <= 1'b0;
					state <= trw_pkg::ST_IDLE;
				end
				default: begin
					prog_en <= 1'b0;
					stall   <= 1'b0;
					state   <= trw_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Flag clears, peripheral acknowledge and vectoring
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_clr   <= 3'h0;
			periph_ack <= 1'b0;
			vector_req <= 1'b0;
		end else begin
			// Peripheral flags are never cleared here
			flag_clr   <= (abort || lw_end || xw_end) ? fast_top : 3'h0;
			periph_ack <= xw_end & ~(|fast) & peri;
			vector_req <= lw_end & ~global_vector_disable;
		end
	end

	// Byte delivered by latch and table reads
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			res_valid <= 1'b0;
			res_data  <= 8'h00;
		end else begin
			res_valid <= issue & (cmd.op == trw_pkg::OP_LATCH_BYTE_READ || is_tr);
			if (issue && (cmd.op == trw_pkg::OP_LATCH_BYTE_READ || is_tr)) begin
				// Old latch contents, so the first read is a dummy
				res_data <= cmd.hi ? program_word_latch[15:8] : program_word_latch[7:0];
			end
		end
	end

	// Events feeding the sticky status bits
	assign events[trw_pkg::EV_LW_END] = lw_end;
	assign events[trw_pkg::EV_ABORT]  = abort;
	assign events[trw_pkg::EV_XW_END] = xw_end;
	assign events[trw_pkg::EV_RD_END] = (state == trw_pkg::ST_RD);

	// Sticky status: a new event beats a same-cycle clear
	genvar gi;
	generate
		for (gi = 0; gi < trw_pkg::EV_NUM; gi++) begin : g_stat
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					status[gi] <= 1'b0;
				end else if (events[gi]) begin
					status[gi] <= 1'b1;
				end else if (wr && addr == trw_pkg::REG_STATUS && wdata[gi]) begin
					status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mode and mask registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode <= trw_pkg::MODE_RESET;
			mask <= 4'h0;
		end else if (wr) begin
			if (addr == trw_pkg::REG_MODE) begin
				mode <= wdata[1:0];
			end
			if (addr == trw_pkg::REG_MASK) begin
				mask <= wdata[3:0];
			end
		end
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// Read data stands in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				trw_pkg::REG_PTR_LO: rdata <= program_word_pointer[7:0];
				trw_pkg::REG_PTR_HI: rdata <= program_word_pointer[15:8];
				trw_pkg::REG_LAT_LO: rdata <= program_word_latch[7:0];
				trw_pkg::REG_LAT_HI: rdata <= program_word_latch[15:8];
				trw_pkg::REG_MODE:   rdata <= {6'h00, mode};
				trw_pkg::REG_STATUS: rdata <= {4'h0, status};
				trw_pkg::REG_MASK:   rdata <= {4'h0, mask};
				trw_pkg::REG_STATE:  rdata <= {4'h0, prog_en, state};
				default:             rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	ext_write_a: assert property ((is_tw && !abort && tw_ext) |->
		##1 !mem_we ##1 (mem_we && stall) ##1 !stall)
		else $error("external write strobe not in second cycle");
	lw_hold_a: assert property ((state == trw_pkg::ST_LW && !term) |=>
		(prog_en && stall))
		else $error("long write dropped without a source");
	lw_end_a: assert property (lw_end |=> (!prog_en && !stall))
		else $error("long write not ended by source");
	vec_gate_a: assert property (lw_end |=>
		(vector_req == !$past(global_vector_disable)))
		else $error("vector request wrong after long write");
	peri_keep_a: assert property ((lw_end && fast == 3'h0) |=>
		(flag_clr == 3'h0))
		else $error("peripheral flag cleared");
	fast_clr_a: assert property ((lw_end && fast != 3'h0) |=>
		($onehot(flag_clr) && (flag_clr & $past(fast)) == flag_clr))
		else $error("fast flag not cleared");
	abort_nop_a: assert property (abort |=>
		(!prog_en && !stall && flag_clr == $past(fast_top) &&
		$stable(program_word_pointer)))
		else $error("aborted write still ran");
	ptr_inc_a: assert property ((inc_now && !wr) |=>
		(program_word_pointer == $past(program_word_pointer) + 16'h0001))
		else $error("pointer did not step");
	ptr_keep_a: assert property ((issue && !cmd.inc && !wr) |=>
		$stable(program_word_pointer))
		else $error("pointer moved without increment");
	rd_reload_a: assert property (is_tr |=> mem_re ##1
		(program_word_latch == $past(mem_rdata)))
		else $error("latch not reloaded by table read");
	latch_hi_a: assert property ((issue && cmd.op == trw_pkg::OP_LATCH_BYTE_WRITE && cmd.hi)
		|=> (program_word_latch[15:8] == $past(cmd.data)))
		else $error("high latch byte not written");

	// Internal write start: the merged latch word and pointer go out together
	lw_start_a: assert property ((is_tw && !abort && !tw_ext) |=>
		(prog_en && stall && !mem_ext && mem_addr == $past(program_word_pointer) &&
		mem_wdata == $past(next_latch)))
		else $error("long write started with wrong word");

	// Processor mode sends every write outside, never into programming
	ext_sel_a: assert property ((is_tw && mode[trw_pkg::MODE_ALL_EXT]) |=>
		(mem_ext && !prog_en))
		else $error("write not routed to external memory");

	// External writes clear the winning fast flag even with sources pending
	ext_clr_a: assert property (xw_end |=> (flag_clr == $past(fast_top)))
		else $error("fast flag not cleared after external write");

	// After an external write a lone peripheral source is acknowledged rather than cleared
	ext_ack_a: assert property ((xw_end && fast == 3'h0 && peri) |=> periph_ack)
		else $error("peripheral not acknowledged after external write");

	// An aborted write must not vector or touch memory
	abort_vec_a: assert property (abort |=> (!vector_req && !mem_we && !mem_re))
		else $error("aborted write had side effects");

	// Read returns the latch byte picked by the select before the reload
	rd_byte_a: assert property (is_tr |=> (res_valid && res_data ==
		($past(cmd.hi) ? $past(program_word_latch[15:8]) :
		$past(program_word_latch[7:0]))))
		else $error("table read returned wrong latch byte");


	lw_vec_c: cover property (lw_end && !global_vector_disable);
	lw_novec_c: cover property (lw_end && global_vector_disable && fast == 3'h0);
	abort_c: cover property (abort);
	ext_wr_c: cover property (xw_end && peri);
	rd_pair_c: cover property (is_tr ##2 is_tr);
endmodule
`default_nettype wire

/* trw_mem_model.sv */
// Purpose: Program memory seen from the table read/write unit
// Assumes: Read data is used in the mem_re cycle or the one after
// Notes:   Unwritten words hold an address pattern
`timescale 1ns/1ns
`default_nettype none
module trw_mem_model (
	// Clock
	input  wire logic        clk,
	// Memory side
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic        mem_re,
	input  wire logic        mem_we,
	input  wire logic        prog_en,
	output var  logic [15:0] mem_rdata
);
	logic [15:0] mem [int];
	logic [15:0] hold   = 16'h0000;
	logic        re_d   = 1'b0;
	logic        prog_d = 1'b0;

	function automatic logic [15:0] word(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : a ^ 16'h5a5a;
	endfunction

	// Whole words are stored on an external strobe or at the start of a long write
	always @(posedge clk) begin
		if (mem_we || (prog_en && !prog_d)) begin
			mem[mem_addr] = mem_wdata;
		end
		re_d <= mem_re;
		prog_d <= prog_en;
		if (mem_re) begin
			hold <= word(mem_addr);
		end
	end

	// Outside the read window the bus shows inverted data so stale words never match
	assign mem_rdata = mem_re ? word(mem_addr) : (re_d ? hold : ~hold);
endmodule
`default_nettype wire

/* tb_table_read_write_unit.sv */
// Purpose: Self-checking bench of the table read/write unit
// Assumes: Memory model answers every read
// Notes:   Internal size shrunk so both memories are cheap to reach
`timescale 1ns/1ns
`default_nettype none
module tb_table_read_write_unit;
	localparam logic [15:0] IW = 16'h0100;
	// Rows: enable and flag, vector disable, expected clear, expected vector
	localparam logic [8:0] ROWS [5] = '{9'h023, 9'h0d4, 9'h110, 9'h101, 9'h089};
	logic                 clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
	logic                 cmd_valid = 1'b0, global_vector_disable = 1'b0;
	logic [3:0]           addr = 4'h0, src_en = 4'h0, src_flag = 4'h0;
	logic [7:0]           wdata = 8'h00, seed = 8'h4a, rdata, res_data;
	trw_pkg::trw_cmd_type cmd = '0;
	logic                 stall, res_valid, periph_ack, vector_req, mem_re, mem_we;
	logic                 prog_en, mem_ext, irq;
	logic [2:0]           flag_clr;
	logic [15:0]          mem_addr, mem_wdata, mem_rdata, lat = 16'h0000;
	logic [15:0]          expq [$];
	int                   bad_count = 0, tests_run = 0;

	trw_unit #(.INT_WORDS(IW)) dut_u (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
		.cmd_valid, .cmd, .stall, .res_valid, .res_data, .src_en, .src_flag,
		.global_vector_disable, .flag_clr, .periph_ack, .vector_req, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_re, .mem_we, .prog_en, .mem_ext, .irq);
	trw_mem_model mem_u (.clk, .mem_addr, .mem_wdata, .mem_re, .mem_we, .prog_en, .mem_rdata);

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Lands just past an edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 9 && stall !== 1'b0; i++) begin
			cyc(1);
		end
		if (i == 9) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
		expq.push_back({8'h00, e});
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic set_ptr(input logic [15:0] p);
		reg_wr(trw_pkg::REG_PTR_LO, p[7:0]);
		reg_wr(trw_pkg::REG_PTR_HI, p[15:8]);
	endtask
	task automatic issue(input trw_pkg::trw_op_type op, input logic hi, input logic inc,
		input logic [7:0] d);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= {op, hi, inc, d};
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask
	// Old latch byte comes back, then the latch holds the next word
	task automatic tread(input logic hi, input logic inc, input logic [15:0] nxt);
		expq.push_back({8'h00, hi ? lat[15:8] : lat[7:0]});
		issue(trw_pkg::OP_TABLE_READ, hi, inc, 8'h00);
		#1;
		check({stall, mem_re}, 2'b11);
		wait_idle();
		lat = nxt;
	endtask

	initial begin
		forever #4 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end
	// Read data is compared in the one cycle it stands, oldest expectation first
	always @(posedge clk) begin
		if (rd_seen || res_valid === 1'b1) begin
			check(rd_seen ? rdata : res_data, expq.pop_front());
		end
		rd_seen <= rd;
	end

	initial begin
		logic [8:0]  row;
		logic [15:0] a;
		logic [15:0] w [5];
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		reg_rd(trw_pkg::REG_STATUS, 8'h00);
		reg_rd(4'h9, 8'h00);
		$display("test reset done");
		// Both latch halves by byte select
		for (int h = 0; h < 4; h++) begin
			seed = lfsr(seed);
			if (h < 2) begin
				lat = h[0] ? {seed, lat[7:0]} : {lat[15:8], seed};
				issue(trw_pkg::OP_LATCH_BYTE_WRITE, h[0], 1'b0, seed);
			end else begin
				expq.push_back({8'h00, h[0] ? lat[15:8] : lat[7:0]});
				issue(trw_pkg::OP_LATCH_BYTE_READ, h[0], 1'b0, seed);
			end
		end
		reg_rd(trw_pkg::REG_LAT_HI, lat[15:8]);
		$display("test latch done");
		// Long writes ended by each kind of source
		reg_wr(trw_pkg::REG_MODE, 8'h01);
		for (int i = 0; i < 5; i++) begin
			row = ROWS[i];
			a = 16'h0010 + 16'(i);
			set_ptr(a);
			seed = lfsr(seed);
			lat[7:0] = seed;
			w[i] = lat;
			@(posedge clk);
			src_en <= row[8:5];
			src_flag <= ~row[8:5]; // Flags raised only on sources that are not enabled, so none ends the write yet
			global_vector_disable <= row[4];
			issue(trw_pkg::OP_TABLE_WRITE, 1'b0, 1'b1, seed);
			cyc(1);
			check({prog_en, mem_ext, mem_addr, mem_wdata}, {2'b10, a, lat});
			cyc(3);
			check(stall, 1'b1);
			@(posedge clk);
			src_flag <= row[8:5];
			wait_idle();
			check({flag_clr, vector_req}, row[3:0]);
			@(posedge clk);
			src_en <= 4'h0;
			src_flag <= 4'h0;
			reg_rd(trw_pkg::REG_PTR_LO, a[7:0] + 8'h01);
		end
		$display("test long write done");
		// Read back: the first read only fills the latch
		set_ptr(16'h000f);
		tread(1'b1, 1'b1, w[0]);
		tread(1'b0, 1'b1, w[1]);
		tread(1'b1, 1'b0, w[1]);
		reg_rd(trw_pkg::REG_PTR_LO, 8'h11);
		$display("test table read done");
		// Pending source turns an internal write into a no-op
		set_ptr(16'h0020);
		@(posedge clk);
		src_en <= 4'he;
		src_flag <= 4'he;
		issue(trw_pkg::OP_TABLE_WRITE, 1'b0, 1'b1, 8'h00);
		#1;
		check({stall, prog_en, flag_clr, vector_req}, 6'b000100);
		reg_rd(trw_pkg::REG_PTR_LO, 8'h20);
		$display("test abort done");
		// External writes run two cycles despite pending sources
		for (int j = 0; j < 2; j++) begin
			a = j ? 16'h0040 : 16'h1234;
			reg_wr(trw_pkg::REG_MODE, j ? 8'h02 : 8'h01);
			set_ptr(a);
			@(posedge clk);
			src_en <= j ? 4'h8 : 4'h3;
			src_flag <= j ? 4'h8 : 4'h3;
			seed = lfsr(seed);
			lat[15:8] = seed;
			issue(trw_pkg::OP_LATCH_BYTE_WRITE, 1'b1, 1'b0, seed);
			seed = lfsr(seed);
			lat[7:0] = seed;
			issue(trw_pkg::OP_TABLE_WRITE, 1'b0, 1'b1, seed);
			#1;
			check({stall, mem_ext, mem_we}, 3'b110);
			cyc(1);
			check({mem_we, mem_addr, mem_wdata}, {1'b1, a, lat});
			cyc(1);
			check({stall, flag_clr, periph_ack}, j ? 5'b00001 : 5'b00010);
			@(posedge clk);
			src_en <= 4'h0;
			src_flag <= 4'h0;
		end
		$display("test external write done");
		// Every event kind has happened; the mask alone gates the interrupt
		reg_rd(trw_pkg::REG_STATUS, 8'h0f);
		check(irq, 1'b0);
		reg_wr(trw_pkg::REG_MASK, 8'h04);
		cyc(2);
		check(irq, 1'b1);
		reg_wr(trw_pkg::REG_STATUS, 8'h04);
		cyc(2);
		check(irq, 1'b0);
		reg_rd(trw_pkg::REG_STATUS, 8'h0b);
		cyc(2);
		$display("test interrupt done");
		complete_run();
	end
endmodule
`default_nettype wire
